//--- design/rdw_consts.svh
// Register offsets, field positions, reset values and sizes of the
// receive descriptor status, fetch and write-back block.
// Assumes byte addressing on a 32-bit APB, one word per register.
`ifndef RDW_CONSTS_SVH
`define RDW_CONSTS_SVH

`define RDW_OFF_CTRL 8'h00
`define RDW_OFF_ETY 8'h04
`define RDW_OFF_THRESH 8'h08
`define RDW_OFF_RING_LEN 8'h0C
`define RDW_OFF_TAIL 8'h10
`define RDW_OFF_FETCH_STAT 8'h14
`define RDW_OFF_WB_STAT 8'h18

`define RDW_RST_ETY 16'h8100
`define RDW_RST_LAYOUT 3'h1
`define RDW_RST_HDR_SIZE 10'h100
`define RDW_RST_PFTH 7'h04
`define RDW_RST_HATH 7'h04
`define RDW_RST_WBTH 7'h00
`define RDW_RST_RING_LEN 16'h0040

`define RDW_LAYOUT_SPLIT 3'h2
`define RDW_LAYOUT_REPL_LARGE 3'h4

`define RDW_ONCHIP_DEPTH 7'h40
`define RDW_LINE_DESC 3'h4
`define RDW_VLAN_BYTES 16'h0004

`define RDW_ST_DN 0
`define RDW_ST_LB 1
`define RDW_ST_VP 3
`define RDW_ST_UC 4
`define RDW_ST_TC 5
`define RDW_ST_IC 6
`define RDW_ST_UV 10
`define RDW_ST_DYNINT 11

`define RDW_ER_IP 11
`define RDW_ER_L4E 10
`define RDW_ER_DE 7
`define RDW_ER_LEN 5
`define RDW_ER_CRC 4
`define RDW_ER_HO 3

`endif

//--- design/rdw_pkg.sv
// Types shared by the receive descriptor block.
// Assumes rdw_consts.svh supplies every number.
package rdw_pkg;

  typedef enum logic [1:0] {
    RDW_IDLE = 2'b01,
    RDW_BUSY = 2'b10
  } rdw_xfer_state_t;

endpackage

//--- design/rdw_desc_compose.sv
// Combinational build of the written-back descriptor fields.
// Assumes packet facts arrive from the parser on the same clock.
`timescale 1ns/10ps
`include "rdw_consts.svh"

module rdw_desc_compose (
  input wire logic store_bad_frames,
  input wire logic vlan_strip_enable,
  input wire logic frag_sum_disable,
  input wire logic ip_payload_sum_enable,
  input wire logic [2:0] descriptor_layout_select,
  input wire logic [9:0] header_buffer_size,
  input wire logic [15:0] vlan_ethertype_value,
  input wire logic pkt_last,
  input wire logic pkt_first,
  input wire logic pkt_dyn_int,
  input wire logic pkt_fe_seen,
  input wire logic pkt_parity_err,
  input wire logic pkt_crc_err,
  input wire logic pkt_len_err,
  input wire logic pkt_ipv4,
  input wire logic pkt_ipv6,
  input wire logic pkt_udp,
  input wire logic pkt_tcp,
  input wire logic pkt_frag,
  input wire logic pkt_first_frag,
  input wire logic pkt_ipv4_bad,
  input wire logic pkt_l4_bad,
  input wire logic [15:0] pkt_udp_hdr_sum,
  input wire logic [15:0] pkt_ethertype,
  input wire logic [15:0] pkt_tag,
  input wire logic pkt_hdr_decoded,
  input wire logic [9:0] pkt_hdr_len,
  input wire logic [15:0] pkt_seg_len,
  input wire logic [15:0] pkt_total_len,
  input wire logic [15:0] pkt_payload_sum,
  input wire logic [15:0] pkt_ip_id,
  input wire logic [31:0] pkt_rss_hash,
  output logic [19:0] status,
  output logic [11:0] error,
  output logic [15:0] packet_buffer_length,
  output logic [15:0] vlan_tag,
  output logic [9:0] parsed_header_length,
  output logic split_header_valid,
  output logic [31:0] hash_word
);

  logic strip;
  logic frag_mode;
  logic hov;
  logic ipc;
  logic l4c;
  logic udpc;
  logic udpok;
  logic [15:0] len;

  always_comb begin
    strip = vlan_strip_enable && (pkt_ethertype == vlan_ethertype_value);
    frag_mode = !frag_sum_disable && ip_payload_sum_enable;
    ipc = pkt_ipv4;
    udpok = 1'b0;
    if (pkt_ipv4 && pkt_frag && frag_mode) begin
      udpc = 1'b1;
      l4c = 1'b0;
      // Zero header sum means the sender skipped it
      udpok = pkt_first_frag && pkt_udp && (pkt_udp_hdr_sum != 16'h0000)
        && !pkt_l4_bad;
    end else if (pkt_ipv4 && !pkt_frag) begin
      udpc = pkt_udp;
      l4c = pkt_udp || pkt_tcp;
    end else begin
      udpc = 1'b0;
      l4c = pkt_ipv6 && !pkt_frag && pkt_tcp;
    end
    hash_word = (frag_mode && pkt_ipv4 && pkt_frag) ?
      {pkt_ip_id, pkt_payload_sum} : pkt_rss_hash;
    split_header_valid = pkt_hdr_decoded;
    parsed_header_length = pkt_hdr_len;
    hov = (descriptor_layout_select == `RDW_LAYOUT_SPLIT) && pkt_hdr_decoded
      && (header_buffer_size < pkt_hdr_len);
    len = pkt_seg_len;
    if (strip && pkt_first) begin
      len = pkt_seg_len - `RDW_VLAN_BYTES;
    end
    if (descriptor_layout_select == `RDW_LAYOUT_SPLIT && pkt_first
        && pkt_hdr_decoded && !hov) begin
      len = len - {6'h00, pkt_hdr_len};
    end else if (descriptor_layout_select == `RDW_LAYOUT_REPL_LARGE
        && pkt_total_len < {6'h00, header_buffer_size}) begin
      len = pkt_total_len;
    end
    // With overflow the header stays in the data buffer, counted in len
    packet_buffer_length = len;
    vlan_tag = (strip && pkt_last) ? pkt_tag : 16'h0000;
    status = 20'h00000;
    status[`RDW_ST_DN] = 1'b1;
    status[`RDW_ST_LB] = pkt_last;
    status[`RDW_ST_VP] = pkt_last && strip;
    status[`RDW_ST_UC] = pkt_last && udpc;
    status[`RDW_ST_TC] = pkt_last && l4c;
    status[`RDW_ST_IC] = pkt_last && ipc;
    status[`RDW_ST_UV] = pkt_last && udpok;
    status[`RDW_ST_DYNINT] = pkt_last && pkt_dyn_int;
    error = 12'h000;
    // Error bits only on the last buffer of a packet
    if (pkt_last) begin
      error[`RDW_ER_IP] = ipc && pkt_ipv4_bad;
      error[`RDW_ER_L4E] = l4c && pkt_l4_bad;
      error[`RDW_ER_DE] = (store_bad_frames && pkt_fe_seen)
        || pkt_parity_err;
      error[`RDW_ER_LEN] = store_bad_frames && pkt_len_err;
      error[`RDW_ER_CRC] = store_bad_frames && pkt_crc_err;
      error[`RDW_ER_HO] = hov;
    end
  end

endmodule

//--- design/rdw_rx_desc.sv
// Receive descriptor status, fetch and write-back control with APB regs.
// Assumes the parser, PCIe engine and timers share mclk; filters are
// elsewhere and never see checksum results.
//
// Notes on behaviour
// - Data error flag on error code in frame, last buffer, bad frames kept.
// - Packet buffer parity fault sets data error flag regardless of storing.
// - IPv4 and transport sum errors flagged, meaningful with computed bits.
// - Checksum failures never affect address or type filtering.
// - CRC and length errors on last buffer, only when bad frames kept.
// - Split mode: header larger than buffer sets overflow, length still given.
// - Sixteen-bit buffer length per descriptor, CRC bytes included.
// - Layout 4, short packet: full packet size reported as length.
// - Layout 2, no split: header plus payload bytes reported.
// - Matching ethertype with stripping: tag copied, four bytes removed, else zero.
// - Tag field: priority 15..13, CFI 12, VLAN id 11..0.
// - Fragment sum offload replaces hash with sum and IP identification.
// - Later fragment: raw payload sum, UDP valid clear, flags 1/0.
// - First UDP fragment: flags 1/0, valid only for nonzero good sum.
// - Unfragmented IPv4: valid clear, flags 1/1 UDP, 0/1 TCP.
// - Empty on-chip store: fetch at once when tail makes descriptors.
// - At prefetch threshold fetch if enough host descriptors and PCIe idle.
// - Trim fetch count so the following fetch starts line aligned.
// - Never fetch at or beyond the software tail.
// - Pack used descriptors per line; flush on threshold, timer, dynamic event.
// - Timer expiry writes all back before interrupt; realign after partials.
// - Error bits: IPv4 11, transport 10, length 5, CRC 4, overflow 3.
// - Done flag set on finished descriptor; with last flag packet complete.
//
// Chosen here: the APB interface to the registers and the register offsets.
`timescale 1ns/10ps
`include "rdw_consts.svh"

module rdw_rx_desc (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic pkt_done,
  input wire logic pkt_last,
  input wire logic pkt_first,
  input wire logic pkt_dyn_int,
  input wire logic pkt_fe_seen,
  input wire logic pkt_parity_err,
  input wire logic pkt_crc_err,
  input wire logic pkt_len_err,
  input wire logic pkt_ipv4,
  input wire logic pkt_ipv6,
  input wire logic pkt_udp,
  input wire logic pkt_tcp,
  input wire logic pkt_frag,
  input wire logic pkt_first_frag,
  input wire logic pkt_ipv4_bad,
  input wire logic pkt_l4_bad,
  input wire logic [15:0] pkt_udp_hdr_sum,
  input wire logic [15:0] pkt_ethertype,
  input wire logic [15:0] pkt_tag,
  input wire logic pkt_hdr_decoded,
  input wire logic [9:0] pkt_hdr_len,
  input wire logic [15:0] pkt_seg_len,
  input wire logic [15:0] pkt_total_len,
  input wire logic [15:0] pkt_payload_sum,
  input wire logic [15:0] pkt_ip_id,
  input wire logic [31:0] pkt_rss_hash,
  output logic desc_valid,
  output logic [19:0] desc_status,
  output logic [11:0] desc_error,
  output logic [15:0] desc_length,
  output logic [15:0] desc_vlan,
  output logic [9:0] desc_hdr_len,
  output logic desc_shv,
  output logic [31:0] desc_hash,
  output logic [15:0] desc_index,
  input wire logic pcie_busy,
  output logic fetch_req,
  output logic [15:0] fetch_index,
  output logic [6:0] fetch_count,
  input wire logic fetch_done,
  input wire logic tmr_expire,
  input wire logic dyn_event,
  output logic wb_req,
  output logic [15:0] wb_index,
  output logic [6:0] wb_count,
  input wire logic wb_done,
  output logic tmr_fire
);

  // Configuration
  logic store_bad_frames_q;
  logic vlan_strip_enable_q;
  logic frag_sum_disable_q;
  logic ip_payload_sum_enable_q;
  logic [2:0] descriptor_layout_select_q;
  logic [9:0] header_buffer_size_q;
  logic [15:0] vlan_ethertype_value_q;
  logic [6:0] prefetch_threshold_q;
  logic [6:0] host_avail_threshold_q;
  logic [6:0] writeback_threshold_q;
  logic [15:0] ring_len_q;
  logic [15:0] tail_q;

  // Bus slave
  logic [31:0] prdata_q;
  logic pready_q;
  logic pslverr_q;
  logic [31:0] rd_d;
  logic miss_d;
  logic apb_wr;

  // Fetch side
  rdw_pkg::rdw_xfer_state_t fetch_st_q;
  logic [15:0] fetch_ptr_q;
  logic [6:0] onchip_q;
  logic [6:0] fetch_cnt_q;
  logic fetch_req_q;
  logic [15:0] avail;
  logic [6:0] free_slots;
  logic [15:0] to_end;
  logic [1:0] misalign;
  logic [6:0] fetch_cnt_d;
  logic fetch_go;

  // Write-back side
  rdw_pkg::rdw_xfer_state_t wb_st_q;
  logic [15:0] wb_ptr_q;
  logic [15:0] use_ptr_q;
  logic [6:0] wb_pend_q;
  logic [6:0] wb_cnt_q;
  logic wb_req_q;
  logic tmr_pend_q;
  logic dyn_pend_q;
  logic tmr_fire_q;
  logic [2:0] line_gap;
  logic [6:0] wb_cnt_d;
  logic wb_go;

  // Descriptor output
  logic [19:0] st_w;
  logic [11:0] er_w;
  logic [15:0] len_w;
  logic [15:0] vlan_w;
  logic [9:0] hlen_w;
  logic shv_w;
  logic [31:0] hash_w;
  logic desc_valid_q;
  logic [19:0] desc_status_q;
  logic [11:0] desc_error_q;
  logic [15:0] desc_length_q;
  logic [15:0] desc_vlan_q;
  logic [9:0] desc_hdr_len_q;
  logic desc_shv_q;
  logic [31:0] desc_hash_q;
  logic [15:0] desc_index_q;

  always_comb begin
    rd_d = 32'h00000000;
    miss_d = 1'b0;
    if (paddr == `RDW_OFF_CTRL) begin
      rd_d = {14'h0000, header_buffer_size_q, 1'b0,
        descriptor_layout_select_q, ip_payload_sum_enable_q,
        frag_sum_disable_q, vlan_strip_enable_q, store_bad_frames_q};
    end else if (paddr == `RDW_OFF_ETY) begin
      rd_d = {16'h0000, vlan_ethertype_value_q};
    end else if (paddr == `RDW_OFF_THRESH) begin
      rd_d = {9'h000, writeback_threshold_q, 1'b0, host_avail_threshold_q,
        1'b0, prefetch_threshold_q};
    end else if (paddr == `RDW_OFF_RING_LEN) begin
      rd_d = {16'h0000, ring_len_q};
    end else if (paddr == `RDW_OFF_TAIL) begin
      rd_d = {16'h0000, tail_q};
    end else if (paddr == `RDW_OFF_FETCH_STAT) begin
      rd_d = {9'h000, onchip_q, fetch_ptr_q};
    end else if (paddr == `RDW_OFF_WB_STAT) begin
      rd_d = {9'h000, wb_pend_q, wb_ptr_q};
    end else begin
      miss_d = 1'b1;
    end
  end

  // One wait state: answer is built from registered read data
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h00000000;
    end else begin
      pready_q <= psel && penable && !pready_q;
      pslverr_q <= psel && penable && !pready_q && miss_d;
      if (psel && penable && !pready_q && !pwrite) begin
        prdata_q <= rd_d;
      end
    end
  end

  assign apb_wr = psel && penable && pwrite && pready_q && !pslverr_q;

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      store_bad_frames_q <= 1'b0;
      vlan_strip_enable_q <= 1'b0;
      frag_sum_disable_q <= 1'b1;
      ip_payload_sum_enable_q <= 1'b0;
      descriptor_layout_select_q <= `RDW_RST_LAYOUT;
      header_buffer_size_q <= `RDW_RST_HDR_SIZE;
      vlan_ethertype_value_q <= `RDW_RST_ETY;
      prefetch_threshold_q <= `RDW_RST_PFTH;
      host_avail_threshold_q <= `RDW_RST_HATH;
      writeback_threshold_q <= `RDW_RST_WBTH;
      ring_len_q <= `RDW_RST_RING_LEN;
      tail_q <= 16'h0000;
    end else if (apb_wr) begin
      if (paddr == `RDW_OFF_CTRL) begin
        store_bad_frames_q <= pwdata[0];
        vlan_strip_enable_q <= pwdata[1];
        frag_sum_disable_q <= pwdata[2];
        ip_payload_sum_enable_q <= pwdata[3];
        descriptor_layout_select_q <= pwdata[6:4];
        header_buffer_size_q <= pwdata[17:8];
      end else if (paddr == `RDW_OFF_ETY) begin
        vlan_ethertype_value_q <= pwdata[15:0];
      end else if (paddr == `RDW_OFF_THRESH) begin
        prefetch_threshold_q <= pwdata[6:0];
        host_avail_threshold_q <= pwdata[14:8];
        writeback_threshold_q <= pwdata[22:16];
      end else if (paddr == `RDW_OFF_RING_LEN) begin
        ring_len_q <= pwdata[15:0];
      end else if (paddr == `RDW_OFF_TAIL) begin
        tail_q <= pwdata[15:0];
      end
    end
  end

  // Fetch sizing; descriptors from fetch pointer up to tail are valid
  always_comb begin
    if (tail_q >= fetch_ptr_q) begin
      avail = tail_q - fetch_ptr_q;
    end else begin
      avail = tail_q + ring_len_q - fetch_ptr_q;
    end
    free_slots = `RDW_ONCHIP_DEPTH - onchip_q;
    to_end = ring_len_q - fetch_ptr_q;
    misalign = fetch_ptr_q[1:0] + free_slots[1:0];
    if (avail > {9'h000, free_slots}) begin
      // Falling behind: shorten so the next burst is line aligned
      if (free_slots > {5'h00, misalign}) begin
        fetch_cnt_d = free_slots - {5'h00, misalign};
      end else begin
        fetch_cnt_d = free_slots;
      end
    end else begin
      fetch_cnt_d = avail[6:0];
    end
    // A burst never wraps past the ring end
    if (to_end < {9'h000, fetch_cnt_d}) begin
      fetch_cnt_d = to_end[6:0];
    end
    fetch_go = (avail != 16'h0000) && (free_slots != 7'h00) &&
      ((onchip_q == 7'h00) ||
       ((onchip_q <= prefetch_threshold_q) &&
        (avail >= {9'h000, host_avail_threshold_q}) &&
        !pcie_busy));
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      fetch_st_q <= rdw_pkg::RDW_IDLE;
      fetch_req_q <= 1'b0;
      fetch_cnt_q <= 7'h00;
      fetch_ptr_q <= 16'h0000;
    end else begin
      case (fetch_st_q)
        rdw_pkg::RDW_IDLE: begin
          if (fetch_go) begin
            fetch_req_q <= 1'b1;
            fetch_cnt_q <= fetch_cnt_d;
            fetch_st_q <= rdw_pkg::RDW_BUSY;
          end
        end
        rdw_pkg::RDW_BUSY: begin
          if (fetch_done) begin
            fetch_req_q <= 1'b0;
            fetch_st_q <= rdw_pkg::RDW_IDLE;
            if (fetch_ptr_q + {9'h000, fetch_cnt_q} >= ring_len_q) begin
              fetch_ptr_q <= fetch_ptr_q + {9'h000, fetch_cnt_q} - ring_len_q;
            end else begin
              fetch_ptr_q <= fetch_ptr_q + {9'h000, fetch_cnt_q};
            end
          end
        end
        default: begin
          fetch_st_q <= rdw_pkg::RDW_IDLE;
          fetch_req_q <= 1'b0;
        end
      endcase
    end
  end

  // Store level: fills on fetch completion, drains one per used descriptor
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      onchip_q <= 7'h00;
    end else begin
      onchip_q <= onchip_q + ((fetch_st_q == rdw_pkg::RDW_BUSY && fetch_done)
        ? fetch_cnt_q : 7'h00) - {6'h00, pkt_done && onchip_q != 7'h00};
    end
  end

  rdw_desc_compose u_compose (
    .store_bad_frames(store_bad_frames_q),
    .vlan_strip_enable(vlan_strip_enable_q),
    .frag_sum_disable(frag_sum_disable_q),
    .ip_payload_sum_enable(ip_payload_sum_enable_q),
    .descriptor_layout_select(descriptor_layout_select_q),
    .header_buffer_size(header_buffer_size_q),
    .vlan_ethertype_value(vlan_ethertype_value_q),
    .pkt_last(pkt_last),
    .pkt_first(pkt_first),
    .pkt_dyn_int(pkt_dyn_int),
    .pkt_fe_seen(pkt_fe_seen),
    .pkt_parity_err(pkt_parity_err),
    .pkt_crc_err(pkt_crc_err),
    .pkt_len_err(pkt_len_err),
    .pkt_ipv4(pkt_ipv4),
    .pkt_ipv6(pkt_ipv6),
    .pkt_udp(pkt_udp),
    .pkt_tcp(pkt_tcp),
    .pkt_frag(pkt_frag),
    .pkt_first_frag(pkt_first_frag),
    .pkt_ipv4_bad(pkt_ipv4_bad),
    .pkt_l4_bad(pkt_l4_bad),
    .pkt_udp_hdr_sum(pkt_udp_hdr_sum),
    .pkt_ethertype(pkt_ethertype),
    .pkt_tag(pkt_tag),
    .pkt_hdr_decoded(pkt_hdr_decoded),
    .pkt_hdr_len(pkt_hdr_len),
    .pkt_seg_len(pkt_seg_len),
    .pkt_total_len(pkt_total_len),
    .pkt_payload_sum(pkt_payload_sum),
    .pkt_ip_id(pkt_ip_id),
    .pkt_rss_hash(pkt_rss_hash),
    .status(st_w),
    .error(er_w),
    .packet_buffer_length(len_w),
    .vlan_tag(vlan_w),
    .parsed_header_length(hlen_w),
    .split_header_valid(shv_w),
    .hash_word(hash_w)
  );

  // Checksum results go only to the descriptor, never to any filter
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      desc_valid_q <= 1'b0;
      desc_status_q <= 20'h00000;
      desc_error_q <= 12'h000;
      desc_length_q <= 16'h0000;
      desc_vlan_q <= 16'h0000;
      desc_hdr_len_q <= 10'h000;
      desc_shv_q <= 1'b0;
      desc_hash_q <= 32'h00000000;
      desc_index_q <= 16'h0000;
      use_ptr_q <= 16'h0000;
    end else begin
      desc_valid_q <= pkt_done;
      if (pkt_done) begin
        desc_status_q <= st_w;
        desc_error_q <= er_w;
        desc_length_q <= len_w;
        desc_vlan_q <= vlan_w;
        desc_hdr_len_q <= hlen_w;
        desc_shv_q <= shv_w;
        desc_hash_q <= hash_w;
        desc_index_q <= use_ptr_q;
        if (use_ptr_q + 16'h0001 >= ring_len_q) begin
          use_ptr_q <= 16'h0000;
        end else begin
          use_ptr_q <= use_ptr_q + 16'h0001;
        end
      end
    end
  end

  // Write-back chunk choice
  always_comb begin
    line_gap = `RDW_LINE_DESC - {1'b0, wb_ptr_q[1:0]};
    wb_go = 1'b0;
    wb_cnt_d = wb_pend_q;
    if ((tmr_pend_q || dyn_pend_q) && wb_pend_q != 7'h00) begin
      wb_go = 1'b1;
    end else if (writeback_threshold_q != 7'h00 &&
        wb_pend_q >= writeback_threshold_q) begin
      wb_go = 1'b1;
    end else if (wb_pend_q >= {4'h0, line_gap}) begin
      // Finishing the partial line first brings writes back in line
      wb_go = 1'b1;
      wb_cnt_d = {4'h0, line_gap};
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      wb_st_q <= rdw_pkg::RDW_IDLE;
      wb_req_q <= 1'b0;
      wb_cnt_q <= 7'h00;
      wb_ptr_q <= 16'h0000;
    end else begin
      case (wb_st_q)
        rdw_pkg::RDW_IDLE: begin
          if (wb_go) begin
            wb_req_q <= 1'b1;
            wb_cnt_q <= wb_cnt_d;
            wb_st_q <= rdw_pkg::RDW_BUSY;
          end
        end
        rdw_pkg::RDW_BUSY: begin
          if (wb_done) begin
            wb_req_q <= 1'b0;
            wb_st_q <= rdw_pkg::RDW_IDLE;
            if (wb_ptr_q + {9'h000, wb_cnt_q} >= ring_len_q) begin
              wb_ptr_q <= wb_ptr_q + {9'h000, wb_cnt_q} - ring_len_q;
            end else begin
              wb_ptr_q <= wb_ptr_q + {9'h000, wb_cnt_q};
            end
          end
        end
        default: begin
          wb_st_q <= rdw_pkg::RDW_IDLE;
          wb_req_q <= 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      wb_pend_q <= 7'h00;
    end else begin
      wb_pend_q <= wb_pend_q + {6'h00, pkt_done} -
        ((wb_st_q == rdw_pkg::RDW_BUSY && wb_done) ? wb_cnt_q : 7'h00);
    end
  end

  // Timer and dynamic events: a new event wins over a same-cycle clear
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      tmr_pend_q <= 1'b0;
      dyn_pend_q <= 1'b0;
      tmr_fire_q <= 1'b0;
    end else begin
      tmr_fire_q <= 1'b0;
      if (tmr_expire) begin
        tmr_pend_q <= 1'b1;
      end else if (tmr_pend_q && wb_pend_q == 7'h00 &&
          wb_st_q == rdw_pkg::RDW_IDLE) begin
        tmr_pend_q <= 1'b0;
        tmr_fire_q <= 1'b1;
      end
      if (dyn_event) begin
        dyn_pend_q <= 1'b1;
      end else if (wb_go && wb_st_q == rdw_pkg::RDW_IDLE) begin
        dyn_pend_q <= 1'b0;
      end else if (wb_pend_q == 7'h00) begin
        dyn_pend_q <= 1'b0;
      end
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign fetch_req = fetch_req_q;
  assign fetch_index = fetch_ptr_q;
  assign fetch_count = fetch_cnt_q;
  assign wb_req = wb_req_q;
  assign wb_index = wb_ptr_q;
  assign wb_count = wb_cnt_q;
  assign tmr_fire = tmr_fire_q;
  assign desc_valid = desc_valid_q;
  assign desc_status = desc_status_q;
  assign desc_error = desc_error_q;
  assign desc_length = desc_length_q;
  assign desc_vlan = desc_vlan_q;
  assign desc_hdr_len = desc_hdr_len_q;
  assign desc_shv = desc_shv_q;
  assign desc_hash = desc_hash_q;
  assign desc_index = desc_index_q;

endmodule

//--- testbench/rdw_rx_desc_checker.sv
// Port assertions for the receive descriptor block.
// Assumes one clock, mclk, and synchronous reset sys_rst.
`timescale 1ns/10ps
module rdw_rx_desc_checker (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic pkt_done,
  input wire logic desc_valid,
  input wire logic [19:0] desc_status,
  input wire logic [11:0] desc_error,
  input wire logic [15:0] desc_vlan,
  input wire logic fetch_req,
  input wire logic fetch_done,
  input wire logic [6:0] fetch_count,
  input wire logic wb_req,
  input wire logic wb_done,
  input wire logic tmr_fire
);
  default clocking @(posedge mclk); endclocking
  default disable iff (sys_rst);
  a_desc_follows: assert property (pkt_done |=> desc_valid)
    else $error("descriptor not reported");
  a_done_set: assert property (desc_valid |-> desc_status[0])
    else $error("done flag missing");
  a_mid_clean: assert property
    (desc_valid && !desc_status[1] |-> desc_error == 12'h000)
    else $error("error bits on middle buffer");
  a_vlan_zero: assert property
    (desc_valid && !desc_status[3] |-> desc_vlan == 16'h0000)
    else $error("tag field not zero");
  a_fetch_hold: assert property
    (fetch_req && !fetch_done |=> fetch_req && $stable(fetch_count))
    else $error("fetch request moved");
  a_fetch_end: assert property
    (fetch_req && fetch_done |=> !fetch_req)
    else $error("fetch outlived completion");
  a_fetch_some: assert property
    (fetch_req |-> fetch_count != 7'h00)
    else $error("empty fetch");
  a_wb_end: assert property (wb_req && wb_done |=> !wb_req)
    else $error("write-back outlived completion");
  a_fire_clean: assert property (tmr_fire |-> !wb_req)
    else $error("interrupt before write-back");
endmodule
bind rdw_rx_desc rdw_rx_desc_checker i_rdw_rx_desc_checker (.*);

//--- testbench/rdw_host_model.sv
// Host memory side: completes fetches and write-backs after lat cycles.
// Assumes requests hold until their done pulse, as the block promises.
`timescale 1ns/10ps
module rdw_host_model (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic [3:0] lat,
  input wire logic fetch_req,
  input wire logic wb_req,
  output logic fetch_done,
  output logic wb_done
);
  logic [3:0] fc_q, wc_q;
  // Latency is variable so slow host memory is exercised too
  always_ff @(posedge mclk) begin
    fc_q <= (!sys_rst && fetch_req && !fetch_done) ? fc_q + 4'h1 : 4'h0;
    fetch_done <= !sys_rst && fetch_req && !fetch_done && fc_q >= lat;
  end
  // Accepts whatever chunk the block packs
  always_ff @(posedge mclk) begin
    wc_q <= (!sys_rst && wb_req && !wb_done) ? wc_q + 4'h1 : 4'h0;
    wb_done <= !sys_rst && wb_req && !wb_done && wc_q >= lat;
  end
endmodule

//--- testbench/rdw_rx_desc_tb.sv
// Self-checking bench for the receive descriptor block.
// Assumes the host model answers fetches and write-backs.
`timescale 1ns/10ps
`include "rdw_consts.svh"
module rdw_rx_desc_tb;
  logic mclk = '0, sys_rst = 1'h1, psel = '0, penable = '0, pwrite = '0;
  logic [7:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, desc_hash, pkt_rss_hash = '1, rd;
  logic pready, pslverr, desc_valid, desc_shv, fetch_req, fetch_done, er;
  logic wb_req, wb_done, tmr_fire, tmr_expire = '0, dyn_event = '0;
  logic pcie_busy = '0, pkt_done = '0, pkt_last = 1'h1, pkt_first = 1'h1;
  logic pkt_dyn_int = '0, pkt_fe_seen = '0, pkt_parity_err = '0;
  logic pkt_crc_err = '0, pkt_len_err = '0, pkt_ipv4 = 1'h1, pkt_ipv6 = '0;
  logic pkt_udp = 1'h1, pkt_tcp = '0, pkt_frag = '0, pkt_first_frag = '0;
  logic pkt_ipv4_bad = '0, pkt_l4_bad = '0, pkt_hdr_decoded = '0;
  logic [9:0] pkt_hdr_len = '0, desc_hdr_len;
  logic [15:0] pkt_udp_hdr_sum = '0, pkt_ethertype = '0, pkt_tag = '0;
  logic [15:0] pkt_seg_len = 16'h0064, pkt_total_len = 16'h0064;
  logic [15:0] pkt_payload_sum = '0, pkt_ip_id = '0, desc_length;
  logic [15:0] desc_vlan, desc_index, fetch_index, wb_index;
  logic [19:0] desc_status;
  logic [11:0] desc_error;
  logic [6:0] fetch_count, wb_count;
  logic [3:0] lat = 4'h1;
  int error_cnt = 0, n_tests = 0, cyc = 0;
  rdw_rx_desc i_rdw_rx_desc (.*);
  rdw_host_model i_rdw_host_model (.*);
  always #5 mclk = ~mclk;
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      error_cnt++;
      report_and_stop();
    end
  end
  task report_and_stop;
    if (error_cnt == 0 && n_tests > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %0t got %0h exp %0h", $time, got, exp);
    end
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'h1;
    do @(posedge mclk); while (pready !== 1'h1);
    rd = prdata;
    er = pslverr;
    psel <= '0;
    penable <= '0;
  endtask
  task send;
    @(posedge mclk);
    pkt_done <= 1'h1;
    @(posedge mclk);
    pkt_done <= '0;
    #1;
    chk(desc_valid, 1);
  endtask
  task s_regs;
    apb(0, `RDW_OFF_ETY, 0);
    chk(rd, 32'h00008100);
    apb(0, `RDW_OFF_RING_LEN, 0);
    chk(rd, 32'h00000040);
    apb(1, 8'h1C, 32'hFFFFFFFF);
    chk(er, 1);
  endtask
  task s_fetch;
    lat <= 4'h3;
    apb(1, `RDW_OFF_TAIL, 32'h00000008);
    while (fetch_req !== 1'h1) @(posedge mclk);
    chk({fetch_index, 9'h000, fetch_count}, 32'h00000008);
    while (fetch_req !== 1'h0) @(posedge mclk);
    apb(0, `RDW_OFF_FETCH_STAT, 0);
    chk(rd[22:16], 32'h00000008);
  endtask
  task s_wb;
    lat <= 4'h6;
    send();
    send();
    tmr_expire <= 1'h1;
    @(posedge mclk);
    tmr_expire <= '0;
    while (wb_req !== 1'h1) @(posedge mclk);
    chk(wb_count, 32'h00000002);
    while (tmr_fire !== 1'h1) @(posedge mclk);
  endtask
  task s_err;
    apb(1, `RDW_OFF_CTRL, 32'h0001001B);
    {pkt_fe_seen, pkt_crc_err, pkt_ipv4_bad, pkt_l4_bad} <= 4'hF;
    pkt_ethertype <= 16'h8100;
    pkt_tag <= 16'hA123;
    send();
    chk(desc_error, 32'h00000C90);
    chk(desc_status, 32'h0000007B);
    chk({desc_vlan, desc_length}, 32'hA1230060);
    apb(1, `RDW_OFF_CTRL, 32'h00010018);
    {pkt_ipv4_bad, pkt_l4_bad, pkt_parity_err} <= 3'h1;
    pkt_ethertype <= 16'h0800;
    send();
    chk(desc_error, 32'h00000080);
    chk({desc_vlan, desc_length}, 32'h00000064);
  endtask
  task s_frag;
    {pkt_fe_seen, pkt_crc_err, pkt_parity_err, pkt_frag} <= 4'h1;
    send();
    chk({desc_status[10], desc_status[5:4]}, 32'h1);
    chk(desc_hash, 32'h00000000);
    pkt_first_frag <= 1'h1;
    pkt_udp_hdr_sum <= 16'h1234;
    send();
    chk({desc_status[10], desc_status[5:4]}, 32'h5);
    pkt_udp_hdr_sum <= 16'h0000;
    send();
    chk({desc_status[10], desc_status[5:4]}, 32'h1);
  endtask
  initial begin
    repeat (8) @(posedge mclk);
    sys_rst <= '0;
    s_regs();
    s_fetch();
    s_wb();
    s_err();
    s_frag();
    report_and_stop();
  end
endmodule
